// ---- verilog/delay_atten_sequencer.sv ----
// Contract
// [RQ1] Soft reset restores defaults, max atten, min delay.
// [RQ2] Controller selects SPI or shift register mode.
// [RQ3] Range 0: 4ps steps, 508ps span.
// [RQ4] Range 1: 2ps steps, 254ps span.
// [RQ5] Attenuation code 0 to 63, 63 maximum.
// [RQ6] Command selects sequencer A or B.
// [RQ7] Commands reset each sequencer to its start.
// [RQ8] Commands toggle each sequencer's stepping direction.
// [RQ9] Load command copies first rank into second.
// [RQ10] Update command and update pin: same trigger.
// [RQ11] 32 entries, each individually writable in first rank.
// [RQ12] Every second-rank entry readable.
// [RQ13] Applied delay and attenuation codes readable.
// [RQ14] Each sequencer has start and stop pointers.
// [RQ15] Update steps active sequencer, applies second rank.
// [RQ16] Ascending at stop wraps to start.
// [RQ17] First update after reset applies start entry.
// [RQ18] Power-up applied state: max atten, min delay.
// [RQ19] All pointers are 5 bits wide.
// [RQ20] Descending at start wraps to stop.
// [RQ21] Delay code is 7 bits wide.
module delay_atten_sequencer #(
    parameter int DEPTH = delay_atten_pkg::TABLE_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Update pin
    input wire logic updatePin,
    // Applied state
    output delay_atten_pkg::stateEntry_t appliedStateOutput,
    output logic [delay_atten_pkg::PS_W-1:0] appliedDelayPs,
    output logic delayRange,
    output delay_atten_pkg::digitalMode_t digitalMode
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic inTable(input logic [11:0] addr, input logic [11:0] base);
        inTable = (addr >= base) && (addr < base + delay_atten_pkg::TABLE_BYTES) && (addr[1:0] == 2'h0);
    endfunction : inTable

    function automatic logic [delay_atten_pkg::PTR_W-1:0] advance(
        input logic [delay_atten_pkg::PTR_W-1:0] ptr,
        input logic [delay_atten_pkg::PTR_W-1:0] start,
        input logic [delay_atten_pkg::PTR_W-1:0] stop,
        input logic asc,
        input logic fresh
    );
        if (fresh) begin
            advance = start; // RQ17
        end else if (asc) begin
            advance = (ptr == stop) ? start : ptr + 5'h01; // RQ16
        end else begin
            advance = (ptr == start) ? stop : ptr - 5'h01; // RQ20
        end
    endfunction : advance

    function automatic logic [31:0] entryWord(input delay_atten_pkg::stateEntry_t e);
        entryWord = 32'h0;
        entryWord[delay_atten_pkg::ENT_DELAY_LSB +: delay_atten_pkg::DELAY_W] = e.delay;
        entryWord[delay_atten_pkg::ENT_ATTEN_LSB +: delay_atten_pkg::ATTEN_W] = e.atten;
    endfunction : entryWord

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef logic [delay_atten_pkg::PS_W-1:0] psWide_t;
    delay_atten_pkg::stateEntry_t rank1_ff [DEPTH];
    delay_atten_pkg::stateEntry_t rank2_ff [DEPTH];
    delay_atten_pkg::stateEntry_t appliedState_ff;
    delay_atten_pkg::stateEntry_t srcEntry;
    delay_atten_pkg::stateEntry_t defEntry;
    delay_atten_pkg::digitalMode_t mode_ff;
    logic [delay_atten_pkg::PTR_W-1:0] seqPtr_ff [2];
    logic [delay_atten_pkg::PTR_W-1:0] seqStart_ff [2];
    logic [delay_atten_pkg::PTR_W-1:0] seqStop_ff [2];
    logic [1:0] seqAsc_ff;
    logic [1:0] seqFresh_ff;
    logic activeSeq_ff;
    logic range_ff;
    logic pinPrev_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [delay_atten_pkg::PS_W-1:0] delayPs_ff;
    logic [delay_atten_pkg::PTR_W-1:0] nxtPtr;
    logic [delay_atten_pkg::CMD_W-1:0] cmd;
    logic [1:0] seqRst;
    logic [1:0] seqTog;
    logic [1:0] seqWr;
    logic apbSetupDone;
    logic wrEn;
    logic softReset;
    logic trigger;
    logic stepNow;
    logic [4:0] wrIdx;

    assign defEntry = '{atten: delay_atten_pkg::ATTEN_MAX, delay: delay_atten_pkg::DELAY_MIN};

    // ------------------------------------------------------------------
    // Bus decode and commands
    // ------------------------------------------------------------------
    assign apbSetupDone = psel && penable && pready_ff;
    assign wrEn = apbSetupDone && pwrite;
    assign wrIdx = paddr[6:2];
    assign cmd = (wrEn && paddr == delay_atten_pkg::OFF_CMD) ? pwdata[delay_atten_pkg::CMD_W-1:0] : '0;
    assign softReset = cmd[delay_atten_pkg::CMD_SOFT_RESET];
    assign seqRst = {cmd[delay_atten_pkg::CMD_RST_B], cmd[delay_atten_pkg::CMD_RST_A]};
    assign seqTog = {cmd[delay_atten_pkg::CMD_TOG_B], cmd[delay_atten_pkg::CMD_TOG_A]};
    assign seqWr = {wrEn && paddr == delay_atten_pkg::OFF_SEQB, wrEn && paddr == delay_atten_pkg::OFF_SEQA};
    assign trigger = (updatePin && !pinPrev_ff) || cmd[delay_atten_pkg::CMD_UPDATE]; // RQ10
    assign stepNow = trigger && !softReset && !seqRst[activeSeq_ff];
    assign nxtPtr = advance(seqPtr_ff[activeSeq_ff], seqStart_ff[activeSeq_ff], seqStop_ff[activeSeq_ff],
                            seqAsc_ff[activeSeq_ff], seqFresh_ff[activeSeq_ff]);
    // A load in the same write as an update applies the freshly loaded entry.
    assign srcEntry = cmd[delay_atten_pkg::CMD_LOAD] ? rank1_ff[nxtPtr] : rank2_ff[nxtPtr]; // RQ15

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinPrev_ff <= 1'b0;
        end else begin
            pinPrev_ff <= updatePin;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            range_ff <= 1'b0;
            mode_ff <= delay_atten_pkg::MODE_SPI;
            activeSeq_ff <= 1'b0;
        end else if (softReset) begin
            range_ff <= 1'b0; // RQ1
            mode_ff <= delay_atten_pkg::MODE_SPI;
            activeSeq_ff <= 1'b0;
        end else begin
            if (wrEn && paddr == delay_atten_pkg::OFF_CTRL) begin
                range_ff <= pwdata[delay_atten_pkg::CTRL_RANGE];
                mode_ff <= delay_atten_pkg::digitalMode_t'(pwdata[delay_atten_pkg::CTRL_MODE]); // RQ2
            end
            if (cmd[delay_atten_pkg::CMD_SEL_B]) begin
                activeSeq_ff <= 1'b1; // RQ6
            end else if (cmd[delay_atten_pkg::CMD_SEL_A]) begin
                activeSeq_ff <= 1'b0; // RQ6
            end
        end
    end

    // ------------------------------------------------------------------
    // State tables
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                rank1_ff[i] <= '{atten: delay_atten_pkg::ATTEN_MAX, delay: delay_atten_pkg::DELAY_MIN};
            end
        end else if (softReset) begin
            for (int i = 0; i < DEPTH; i++) begin
                rank1_ff[i] <= defEntry; // RQ1
            end
        end else if (wrEn && inTable(paddr, delay_atten_pkg::OFF_RANK1)) begin
            rank1_ff[wrIdx].delay <= pwdata[delay_atten_pkg::ENT_DELAY_LSB +: delay_atten_pkg::DELAY_W]; // RQ11 RQ21
            rank1_ff[wrIdx].atten <= pwdata[delay_atten_pkg::ENT_ATTEN_LSB +: delay_atten_pkg::ATTEN_W]; // RQ5
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) begin
                rank2_ff[i] <= '{atten: delay_atten_pkg::ATTEN_MAX, delay: delay_atten_pkg::DELAY_MIN};
            end
        end else if (softReset) begin
            for (int i = 0; i < DEPTH; i++) begin
                rank2_ff[i] <= defEntry;
            end
        end else if (cmd[delay_atten_pkg::CMD_LOAD]) begin
            for (int i = 0; i < DEPTH; i++) begin
                rank2_ff[i] <= rank1_ff[i]; // RQ9
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int s = 0; s < 2; s++) begin
                seqPtr_ff[s] <= delay_atten_pkg::PTR_RST_START;
                seqStart_ff[s] <= delay_atten_pkg::PTR_RST_START;
                seqStop_ff[s] <= delay_atten_pkg::PTR_RST_STOP;
            end
            seqAsc_ff <= 2'h3;
            seqFresh_ff <= 2'h3;
        end else if (softReset) begin
            for (int s = 0; s < 2; s++) begin
                seqPtr_ff[s] <= delay_atten_pkg::PTR_RST_START;
                seqStart_ff[s] <= delay_atten_pkg::PTR_RST_START;
                seqStop_ff[s] <= delay_atten_pkg::PTR_RST_STOP;
            end
            seqAsc_ff <= 2'h3;
            seqFresh_ff <= 2'h3;
        end else begin
            for (int s = 0; s < 2; s++) begin
                if (seqWr[s]) begin
                    seqStart_ff[s] <= pwdata[delay_atten_pkg::SEQ_START_LSB +: delay_atten_pkg::PTR_W]; // RQ14 RQ19
                    seqStop_ff[s] <= pwdata[delay_atten_pkg::SEQ_STOP_LSB +: delay_atten_pkg::PTR_W]; // RQ14 RQ19
                    seqAsc_ff[s] <= pwdata[delay_atten_pkg::SEQ_DIR];
                end
                if (seqTog[s]) begin
                    seqAsc_ff[s] <= !seqAsc_ff[s]; // RQ8
                end
                if (seqRst[s]) begin
                    seqPtr_ff[s] <= seqStart_ff[s]; // RQ7
                    seqFresh_ff[s] <= 1'b1; // RQ17
                end else if (stepNow && activeSeq_ff == s[0]) begin
                    seqPtr_ff[s] <= nxtPtr; // RQ15
                    seqFresh_ff[s] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Applied state
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            appliedState_ff <= '{atten: delay_atten_pkg::ATTEN_MAX, delay: delay_atten_pkg::DELAY_MIN}; // RQ18
        end else if (softReset) begin
            appliedState_ff <= defEntry; // RQ1
        end else if (stepNow) begin
            appliedState_ff <= srcEntry; // RQ15
        end
    end

    // The delay in picoseconds follows the applied code by one cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            delayPs_ff <= '0;
        end else if (range_ff) begin
            delayPs_ff <= psWide_t'(appliedState_ff.delay) * delay_atten_pkg::STEP_PS_RANGE1; // RQ4
        end else begin
            delayPs_ff <= psWide_t'(appliedState_ff.delay) * delay_atten_pkg::STEP_PS_RANGE0; // RQ3
        end
    end

    // ------------------------------------------------------------------
    // APB response
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else if (psel && penable && !pready_ff) begin
            pready_ff <= 1'b1;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
            if (inTable(paddr, delay_atten_pkg::OFF_RANK1)) begin
                prdata_ff <= entryWord(rank1_ff[wrIdx]);
            end else if (inTable(paddr, delay_atten_pkg::OFF_RANK2)) begin
                prdata_ff <= entryWord(rank2_ff[wrIdx]); // RQ12
            end else if (paddr == delay_atten_pkg::OFF_CTRL) begin
                prdata_ff[delay_atten_pkg::CTRL_RANGE] <= range_ff;
                prdata_ff[delay_atten_pkg::CTRL_MODE] <= mode_ff;
                prdata_ff[delay_atten_pkg::CTRL_ACTIVE] <= activeSeq_ff;
            end else if (paddr == delay_atten_pkg::OFF_SEQA || paddr == delay_atten_pkg::OFF_SEQB) begin
                prdata_ff[delay_atten_pkg::SEQ_START_LSB +: delay_atten_pkg::PTR_W] <= seqStart_ff[paddr[2]];
                prdata_ff[delay_atten_pkg::SEQ_STOP_LSB +: delay_atten_pkg::PTR_W] <= seqStop_ff[paddr[2]];
                prdata_ff[delay_atten_pkg::SEQ_DIR] <= seqAsc_ff[paddr[2]];
                prdata_ff[delay_atten_pkg::SEQ_PTR_LSB +: delay_atten_pkg::PTR_W] <= seqPtr_ff[paddr[2]];
            end else if (paddr == delay_atten_pkg::OFF_APPLIED) begin
                prdata_ff <= entryWord(appliedState_ff); // RQ13
                prdata_ff[delay_atten_pkg::APP_RANGE] <= range_ff;
                prdata_ff[delay_atten_pkg::APP_ACTIVE] <= activeSeq_ff;
            end else if (paddr != delay_atten_pkg::OFF_CMD) begin
                pslverr_ff <= 1'b1;
            end
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign appliedStateOutput = appliedState_ff;
    assign appliedDelayPs = delayPs_ff;
    assign delayRange = range_ff;
    assign digitalMode = mode_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence seqResetA;
        seqRst[0] && !softReset && activeSeq_ff == 1'b0;
    endsequence

    sequence firstStepA;
        stepNow && !seqRst[0] && activeSeq_ff == 1'b0 && seqFresh_ff[0];
    endsequence

    AST_SOFT_RESET: assert property (softReset |=> appliedState_ff == defEntry && !range_ff) // RQ1
        else $error("soft reset did not restore applied state");
    AST_DELAY_SPAN: assert property (delayPs_ff <= ($past(range_ff) ? delay_atten_pkg::SPAN_PS_RANGE1 :
                                                    delay_atten_pkg::SPAN_PS_RANGE0)) // RQ3
        else $error("delay span exceeded");
    AST_DELAY_R1: assert property (range_ff ##1 (range_ff && $stable(appliedState_ff))
                                   |-> delayPs_ff == psWide_t'(appliedState_ff.delay) * delay_atten_pkg::STEP_PS_RANGE1) // RQ4
        else $error("range 1 delay step wrong");
    AST_SELECT_B: assert property (cmd[delay_atten_pkg::CMD_SEL_B] && !softReset |=> activeSeq_ff) // RQ6
        else $error("sequencer B not selected");
    AST_TOGGLE: assert property (seqTog[0] && !seqWr[0] && !softReset |=> seqAsc_ff[0] != $past(seqAsc_ff[0])) // RQ8
        else $error("direction of sequencer A did not toggle");
    AST_LOAD: assert property (cmd[delay_atten_pkg::CMD_LOAD] && !softReset
                               |=> rank2_ff[seqPtr_ff[0]] == $past(rank1_ff[seqPtr_ff[0]]) || $changed(seqPtr_ff[0])) // RQ9
        else $error("load did not copy first rank");
    AST_PIN_TRIGGER: assert property ($rose(updatePin) && !softReset && !seqRst[activeSeq_ff]
                                      |=> appliedState_ff == rank2_ff[seqPtr_ff[$past(activeSeq_ff)]]) // RQ10
        else $error("update pin did not apply an entry");
    AST_STEP_APPLY: assert property (stepNow |=> appliedState_ff == rank2_ff[seqPtr_ff[$past(activeSeq_ff)]]) // RQ15
        else $error("applied state differs from second rank entry");
    AST_WRAP_UP: assert property (stepNow && seqAsc_ff[activeSeq_ff] && !seqFresh_ff[activeSeq_ff]
                                  && seqPtr_ff[activeSeq_ff] == seqStop_ff[activeSeq_ff]
                                  |=> seqPtr_ff[$past(activeSeq_ff)] == $past(seqStart_ff[activeSeq_ff])) // RQ16
        else $error("ascending sequencer did not wrap to start");
    AST_SEQ_RESET_A: assert property (seqResetA |=> seqFresh_ff[0] && seqPtr_ff[0] == $past(seqStart_ff[0])) // RQ7
        else $error("sequencer A reset did not return to start");
    AST_FIRST_AFTER_RESET: assert property (firstStepA |=> seqPtr_ff[0] == $past(seqStart_ff[0]) && !seqFresh_ff[0]) // RQ17
        else $error("first update after reset missed start entry");
    AST_WRAP_DOWN: assert property (stepNow && !seqAsc_ff[activeSeq_ff] && !seqFresh_ff[activeSeq_ff]
                                    && seqPtr_ff[activeSeq_ff] == seqStart_ff[activeSeq_ff]
                                    |=> seqPtr_ff[$past(activeSeq_ff)] == $past(seqStop_ff[activeSeq_ff])) // RQ20
        else $error("descending sequencer did not wrap to stop");
    AST_APB_ANSWER: assert property (psel && penable && !pready_ff |=> pready_ff ##1 !pready_ff)
        else $error("APB answer not one cycle after access start");

endmodule : delay_atten_sequencer

// ---- verilog/delay_atten_pkg.sv ----
package delay_atten_pkg;

    // ------------------------------------------------------------------
    // Table and code widths
    // ------------------------------------------------------------------
    localparam int TABLE_DEPTH = 32;
    localparam int PTR_W = 5;
    localparam int DELAY_W = 7;
    localparam int ATTEN_W = 6;
    localparam int PS_W = 10;

    typedef struct packed {
        logic [ATTEN_W-1:0] atten;
        logic [DELAY_W-1:0] delay;
    } stateEntry_t;

    typedef enum logic {MODE_SPI, MODE_SHIFT} digitalMode_t;

    // ------------------------------------------------------------------
    // Reset values and delay steps
    // ------------------------------------------------------------------
    localparam logic [ATTEN_W-1:0] ATTEN_MAX = 6'h3f;
    localparam logic [DELAY_W-1:0] DELAY_MIN = 7'h00;
    localparam logic [PTR_W-1:0] PTR_RST_START = 5'h00;
    localparam logic [PTR_W-1:0] PTR_RST_STOP = 5'h1f;
    localparam logic [PS_W-1:0] STEP_PS_RANGE0 = 10'h004;
    localparam logic [PS_W-1:0] STEP_PS_RANGE1 = 10'h002;
    localparam logic [PS_W-1:0] SPAN_PS_RANGE0 = 10'h1fc;
    localparam logic [PS_W-1:0] SPAN_PS_RANGE1 = 10'h0fe;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_CMD = 12'h004;
    localparam logic [11:0] OFF_SEQA = 12'h008;
    localparam logic [11:0] OFF_SEQB = 12'h00c;
    localparam logic [11:0] OFF_APPLIED = 12'h010;
    localparam logic [11:0] OFF_RANK1 = 12'h100;
    localparam logic [11:0] OFF_RANK2 = 12'h200;
    localparam logic [11:0] TABLE_BYTES = 12'h080;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_RANGE = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_ACTIVE = 2;
    localparam int CMD_SOFT_RESET = 0;
    localparam int CMD_SEL_A = 1;
    localparam int CMD_SEL_B = 2;
    localparam int CMD_RST_A = 3;
    localparam int CMD_RST_B = 4;
    localparam int CMD_TOG_A = 5;
    localparam int CMD_TOG_B = 6;
    localparam int CMD_LOAD = 7;
    localparam int CMD_UPDATE = 8;
    localparam int CMD_W = 9;
    localparam int ENT_DELAY_LSB = 0;
    localparam int ENT_ATTEN_LSB = 8;
    localparam int SEQ_START_LSB = 0;
    localparam int SEQ_STOP_LSB = 8;
    localparam int SEQ_DIR = 16;
    localparam int SEQ_PTR_LSB = 24;
    localparam int APP_RANGE = 16;
    localparam int APP_ACTIVE = 17;

endpackage : delay_atten_pkg

// ---- tb/update_driver.sv ----
module update_driver (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request from the bench
    input wire logic fire,
    // Pin toward the device
    output logic updatePin
);
    timeunit 1ns;
    timeprecision 1ps;
    // A held request toggles the pin every cycle, so the device sees a rising edge every second cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            updatePin <= 1'b0;
        end else begin
            updatePin <= fire && !updatePin;
        end
    end
endmodule : update_driver

// ---- tb/test_delay_atten_state_sequencer.sv ----
module test_delay_atten_state_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fire = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, updatePin, delayRange, err;
    delay_atten_pkg::stateEntry_t st;
    logic [delay_atten_pkg::PS_W-1:0] appliedDelayPs;
    delay_atten_pkg::digitalMode_t digitalMode;
    int n_fail = 0, n_tests = 0, cycles = 0;
    always #2.5 clk = ~clk;
    delay_atten_sequencer DUT (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .updatePin(updatePin), .appliedStateOutput(st), .appliedDelayPs(appliedDelayPs),
        .delayRange(delayRange), .digitalMode(digitalMode));
    update_driver partner (.clk(clk), .rst_b(rst_b), .fire(fire), .updatePin(updatePin));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Table entry i holds delay 4*i and attenuation 63-i, in the readback word layout.
    function automatic logic [31:0] ent(input int i);
        ent = {18'h0, 6'(63 - i), 1'b0, 7'(i * 4)};
    endfunction : ent
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic cmd(input int b);
        xfer(1'b1, delay_atten_pkg::OFF_CMD, 32'h1 << b);
    endtask : cmd
    task automatic pulse;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse
    task automatic app(input int i);
        xfer(1'b0, delay_atten_pkg::OFF_APPLIED, 32'h0);
        chk({18'h0, rd[13:0]}, ent(i));
        chk({18'h0, st.atten, 1'b0, st.delay}, ent(i));
    endtask : app
    task automatic stop_test;
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("[FAIL] %0t run took too long", $time);
            stop_test();
        end
    end
    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        chk({18'h0, st.atten, 1'b0, st.delay}, ent(0));
        xfer(1'b0, delay_atten_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 32; i++) xfer(1'b1, delay_atten_pkg::OFF_RANK1 + 12'(4 * i), ent(i));
        xfer(1'b0, delay_atten_pkg::OFF_RANK2 + 12'h014, 32'h0);
        chk(rd, ent(0));
        cmd(delay_atten_pkg::CMD_LOAD);
        for (int i = 0; i < 32; i++) begin
            xfer(1'b0, delay_atten_pkg::OFF_RANK2 + 12'(4 * i), 32'h0);
            chk(rd, ent(i));
        end
        xfer(1'b0, 12'h050, 32'h0);
        chk({31'h0, err}, 32'h1);
        xfer(1'b1, delay_atten_pkg::OFF_SEQA, 32'h0001_0402);
        cmd(delay_atten_pkg::CMD_RST_A);
        cmd(delay_atten_pkg::CMD_UPDATE);
        app(2);
        pulse();
        app(3);
        cmd(delay_atten_pkg::CMD_UPDATE);
        app(4);
        pulse();
        app(2);
        cmd(delay_atten_pkg::CMD_TOG_A);
        cmd(delay_atten_pkg::CMD_UPDATE);
        app(4);
        cmd(delay_atten_pkg::CMD_UPDATE);
        app(3);
        xfer(1'b1, delay_atten_pkg::OFF_SEQB, 32'h0001_0c0a);
        cmd(delay_atten_pkg::CMD_SEL_B);
        cmd(delay_atten_pkg::CMD_RST_B);
        pulse();
        app(10);
        xfer(1'b0, delay_atten_pkg::OFF_SEQB, 32'h0);
        chk(rd, 32'h0a01_0c0a);
        cmd(delay_atten_pkg::CMD_SEL_A);
        cmd(delay_atten_pkg::CMD_UPDATE);
        app(2);
        chk({22'h0, appliedDelayPs}, 32'h20);
        xfer(1'b1, delay_atten_pkg::OFF_CTRL, 32'h3);
        repeat (3) @(posedge clk);
        chk({22'h0, appliedDelayPs}, 32'h10);
        chk({30'h0, digitalMode, delayRange}, 32'h3);
        cmd(delay_atten_pkg::CMD_SOFT_RESET);
        app(0);
        xfer(1'b0, delay_atten_pkg::OFF_RANK2 + 12'h014, 32'h0);
        chk(rd, ent(0));
        xfer(1'b0, delay_atten_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        stop_test();
    end
endmodule : test_delay_atten_state_sequencer
